// *** etl_pkg.sv ***
package etl_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_LINE  = 8'h04;
	localparam logic [7:0] OFS_DROP  = 8'h08;
	localparam logic [7:0] OFS_MULT  = 8'h0c;
	localparam logic [7:0] OFS_FRAME = 8'h10;
	localparam logic [7:0] OFS_LINES = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h18;
	localparam logic [7:0] OFS_CNT   = 8'h1c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_ENC   = 0;
	localparam int CTRL_EXT   = 1;
	localparam int CTRL_FTRIG = 2;
	localparam int CTRL_GRAB  = 3;
	localparam int CTRL_AUTO  = 4;
	localparam int CTRL_TF    = 5;
	localparam int CTRL_VAR   = 6;
	localparam int LINE_SRC   = 0;
	localparam int LINE_ORD   = 4;
	localparam int LINE_DIR   = 8;
	localparam int STAT_REV   = 16;
	localparam int STAT_DUAL  = 28;
	localparam int STAT_HELD  = 29;
	localparam int STAT_BUSY  = 30;
	localparam int STAT_RUN   = 31;
	localparam int CNT_DROP   = 16;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_A     = 3'h1;
	localparam logic [2:0] SRC_B     = 3'h2;
	localparam logic [2:0] SRC_AB    = 3'h3;
	localparam logic [2:0] SRC_SYNC1 = 3'h4;
	localparam logic [2:0] SRC_SYNC2 = 3'h5;
	localparam logic [1:0] ORD_DROP1 = 2'h1;
	localparam logic [1:0] DIR_IGN   = 2'h0;
	localparam logic [1:0] DIR_AB    = 2'h1;
	localparam logic [6:0] DET_LOW   = 7'h01;
	localparam logic [6:0] DET_HIGH  = 7'h02;
	localparam logic [6:0] DET_RISE  = 7'h04;
	localparam logic [6:0] DET_FALL  = 7'h08;
	localparam logic [6:0] DET_DRISE = 7'h20;
	localparam logic [6:0] DET_DFALL = 7'h40;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       enc_on;
		logic       ext_on;
		logic       ftrig_on;
		logic       grab;
		logic       auto_dly;
		logic       tf_en;
		logic       var_len;
		logic [2:0] src;
		logic [1:0] order;
		logic [1:0] dir;
		logic [15:0] drop;
		logic [7:0] mult;
		logic [6:0] det;
		logic [15:0] lines;
	} etl_cfg_t;

	typedef struct packed {
		logic enc_a;
		logic enc_b;
		logic sync1;
		logic sync2;
		logic trig1;
		logic trig2;
	} etl_pins_t;

	typedef struct packed {
		logic valid;
		logic dropped;
		logic too_fast;
		logic rev_ovf;
		logic fstart;
		logic fend;
	} etl_ev_t;

	typedef enum logic [1:0] {
		F_IDLE = 2'b01,
		F_RUN  = 2'b10
	} etl_fst_t;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  SRC_RST   = 3'h1;
	localparam logic [7:0]  MULT_RST  = 8'h01;
	localparam logic [15:0] LINES_RST = 16'h0400;
	localparam logic [6:0]  DET_RST   = 7'h04;

endpackage : etl_pkg

// *** etl_trigger.sv ***
// Contract
// - source code 1 phase A, 2 phase B, 3 both, 4 sync one, 5 sync two
// - encoder mode: one line trigger per qualifying edge on either phase
// - after each passed pulse, drop the programmed count of pulses
// - multiply emits the programmed number of triggers per input pulse
// - order 1 drops then multiplies; 0 or 2 multiplies then drops
// - direction 0 ignored, 1 A leads forward, 2 B leads forward
// - count reverse steps, pay back with forward steps, then trigger
// - reverse counter overflow raises an event
// - auto delay holds a trigger until the camera line is done
// - encoder enable 1 turns encoder triggering on, 0 off
// - fixed mode captures exactly the programmed line count, one line when it is 0
// - variable level or dual frames end on deassert or at the maximum
// - level and dual modes roll over while the condition stays active
// - single edge modes capture one frame per edge, never roll over
// - frame trigger events only while grabbing
// - fixed mode checks level at frame end, restarts or waits
// - variable mode never reports ignored triggers
// - frame trigger enable 1 on, 0 off
// - detection 1 low, 2 high, 4 rise, 8 fall, 32/64 dual edges
// - dual input: input one edge starts, input two edge ends
// - line triggers run on regardless of frame state
// - fixed mode: each received trigger is valid or ignored
// - too fast event at most once per virtual frame
// - trigger during a running fixed frame is ignored and reported
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module etl_trigger #(
	parameter int REV_W = 8
) (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// encoder, sync and frame trigger pins
	input  wire etl_pkg::etl_pins_t  pins,
	// camera side
	input  wire logic                line_done,
	output logic                     line_trigger,
	output logic                     line_capture,
	output logic                     frame_active,
	// events
	output etl_pkg::etl_ev_t         events
);

	generate
		if (REV_W < 1 || REV_W > 12) begin : g_bad_rev
			$error("REV_W must lie in 1..12");
		end
	endgenerate

	typedef struct packed {
		etl_pkg::etl_cfg_t  cfg;
		etl_pkg::etl_pins_t s1;
		etl_pkg::etl_pins_t s2;
		etl_pkg::etl_pins_t s3;
		logic [31:0]        rdata;
		logic [REV_W-1:0]   rev;
		logic [15:0]        dcnt;
		logic [15:0]        mpend;
		logic [15:0]        lcnt;
		logic [15:0]        vcnt;
		logic [15:0]        icnt;
		logic               busy;
		logic               held;
		logic               tf_seen;
		logic               dual_on;
		logic               ltrig;
		logic               lcap;
		etl_pkg::etl_fst_t  fst;
		etl_pkg::etl_ev_t   ev;
	} etl_st_t;

	etl_st_t q;
	etl_st_t n;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [16:0] drop_step(input logic in, input logic [15:0] cnt,
		input logic [15:0] rld);
		if (!in)
			return {1'b0, cnt};
		if (cnt == 16'h0000)
			return {1'b1, rld};
		return {1'b0, cnt - 16'h0001};
	endfunction : drop_step

	// one trigger per cycle; extra copies queue in the pending count
	function automatic logic [16:0] mult_step(input logic in, input logic [15:0] pend,
		input logic [7:0] m);
		logic       o;
		logic [7:0] k;
		o = in | (pend != 16'h0000);
		k = (m == 8'h00) ? 8'h01 : m;
		return {o, pend + (in ? {8'h00, k} : 16'h0000) - {15'h0000, o}};
	endfunction : mult_step

	function automatic logic mapped(input logic [7:0] a);
		return a inside {etl_pkg::OFS_CTRL, etl_pkg::OFS_LINE, etl_pkg::OFS_DROP,
			etl_pkg::OFS_MULT, etl_pkg::OFS_FRAME, etl_pkg::OFS_LINES,
			etl_pkg::OFS_STAT, etl_pkg::OFS_CNT};
	endfunction : mapped

	// ------------------------------------------------------------
	// combinational next state
	// ------------------------------------------------------------
	logic        ea, eb, ra, rb, fwd, raw, qual, p, issue;
	logic        t1r, t1f, t2r, t2f, lvl, dual, edg, lvl_act;
	logic        sedge, eedge, cond, armed, line_in, done_len, vend, fwd_p, rev_p;
	logic [15:0] lim;
	logic [16:0] ds, ms;
	logic [31:0] rv;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);

	always_comb begin
		n = q;
		n.s1 = pins;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.ev = '0;
		n.ltrig = 1'b0;
		n.lcap = 1'b0;

		// encoder edges and quadrature direction
		ea = q.s2.enc_a ^ q.s3.enc_a;
		eb = q.s2.enc_b ^ q.s3.enc_b;
		ra = q.s2.enc_a & ~q.s3.enc_a;
		rb = q.s2.enc_b & ~q.s3.enc_b;
		fwd = ea ? (q.s2.enc_a != q.s2.enc_b) : (q.s2.enc_b == q.s2.enc_a);
		if (q.cfg.dir != etl_pkg::DIR_AB)
			fwd = ~fwd;

		raw = 1'b0;
		if (q.cfg.enc_on) begin
			case (q.cfg.src)
				etl_pkg::SRC_A:  raw = ea;
				etl_pkg::SRC_B:  raw = eb;
				etl_pkg::SRC_AB: raw = ea | eb;
				default:         raw = 1'b0;
			endcase
		end else if (q.cfg.ext_on) begin
			case (q.cfg.src)
				etl_pkg::SRC_A:     raw = ra;
				etl_pkg::SRC_B:     raw = rb;
				etl_pkg::SRC_SYNC1: raw = q.s2.sync1 & ~q.s3.sync1;
				etl_pkg::SRC_SYNC2: raw = q.s2.sync2 & ~q.s3.sync2;
				default:            raw = 1'b0;
			endcase
		end

		// direction qualification with reverse step payback
		qual = raw;
		fwd_p = 1'b0;
		rev_p = 1'b0;
		if (raw && q.cfg.enc_on && q.cfg.dir != etl_pkg::DIR_IGN) begin
			fwd_p = fwd;
			rev_p = ~fwd;
			qual = 1'b0;
			if (fwd && q.rev != '0)
				n.rev = q.rev - 1'b1;
			else if (fwd)
				qual = 1'b1;
			else if (&q.rev)
				n.ev.rev_ovf = 1'b1;
			else
				n.rev = q.rev + 1'b1;
		end

		// drop and multiply, order selectable
		if (q.cfg.order == etl_pkg::ORD_DROP1) begin
			ds = drop_step(qual, q.dcnt, q.cfg.drop);
			ms = mult_step(ds[16], q.mpend, q.cfg.mult);
			p = ms[16];
		end else begin
			ms = mult_step(qual, q.mpend, q.cfg.mult);
			ds = drop_step(ms[16], q.dcnt, q.cfg.drop);
			p = ds[16];
		end
		n.dcnt = ds[15:0];
		n.mpend = ms[15:0];

		// line trigger with optional auto delay
		issue = 1'b0;
		n.busy = q.busy & ~line_done;
		if (q.cfg.auto_dly) begin
			if ((p || q.held) && !q.busy) begin
				issue = 1'b1;
				n.held = q.held & p;
			end else if (p || q.held) begin
				n.held = 1'b1;
				if (p && q.cfg.tf_en && !q.tf_seen) begin
					n.ev.too_fast = 1'b1;
					n.tf_seen = 1'b1;
				end
			end
		end else begin
			issue = p;
			n.held = 1'b0;
		end
		if (issue) begin
			n.busy = 1'b1;
			n.ltrig = 1'b1;
		end

		// frame trigger detection
		t1r = q.s2.trig1 & ~q.s3.trig1;
		t1f = ~q.s2.trig1 & q.s3.trig1;
		t2r = q.s2.trig2 & ~q.s3.trig2;
		t2f = ~q.s2.trig2 & q.s3.trig2;
		lvl = (q.cfg.det == etl_pkg::DET_LOW) || (q.cfg.det == etl_pkg::DET_HIGH);
		dual = (q.cfg.det == etl_pkg::DET_DRISE) || (q.cfg.det == etl_pkg::DET_DFALL);
		edg = (q.cfg.det == etl_pkg::DET_RISE) || (q.cfg.det == etl_pkg::DET_FALL);
		lvl_act = (q.cfg.det == etl_pkg::DET_LOW) ? ~q.s2.trig1 : q.s2.trig1;
		case (q.cfg.det)
			etl_pkg::DET_LOW:   begin sedge = t1f; eedge = t1r; end
			etl_pkg::DET_HIGH:  begin sedge = t1r; eedge = t1f; end
			etl_pkg::DET_RISE:  begin sedge = t1r; eedge = 1'b0; end
			etl_pkg::DET_FALL:  begin sedge = t1f; eedge = 1'b0; end
			etl_pkg::DET_DRISE: begin sedge = t1r; eedge = t2r; end
			etl_pkg::DET_DFALL: begin sedge = t1f; eedge = t2f; end
			default:            begin sedge = 1'b0; eedge = 1'b0; end
		endcase
		if (dual && sedge)
			n.dual_on = 1'b1;
		else if (dual && eedge || !dual)
			n.dual_on = 1'b0;
		cond = lvl ? lvl_act : (dual & n.dual_on);

		armed = q.cfg.grab & q.cfg.ftrig_on;
		lim = (q.cfg.lines == 16'h0000) ? 16'h0001 : q.cfg.lines;
		line_in = issue && q.fst == etl_pkg::F_RUN;
		done_len = line_in && (q.lcnt + 16'h0001 == lim);
		vend = armed && q.cfg.var_len && (lvl || dual) && eedge;
		n.lcap = line_in;

		case (q.fst)
			etl_pkg::F_IDLE: begin
				if (q.cfg.grab && (!q.cfg.ftrig_on || armed && (sedge || cond && !edg))) begin
					n.fst = etl_pkg::F_RUN;
					n.lcnt = 16'h0000;
					n.tf_seen = n.ev.too_fast;
					n.ev.fstart = 1'b1;
					n.ev.valid = armed & sedge;
				end
			end
			etl_pkg::F_RUN: begin
				if (line_in)
					n.lcnt = q.lcnt + 16'h0001;
				if (!q.cfg.grab || vend) begin
					n.fst = etl_pkg::F_IDLE;
					n.ev.fend = 1'b1;
					n.ev.valid = vend;
				end else if (done_len) begin
					n.ev.fend = 1'b1;
					if (!q.cfg.ftrig_on || cond) begin
						n.lcnt = 16'h0000;
						// a too-fast hit in the roll cycle counts for the new frame
						n.tf_seen = n.ev.too_fast;
						n.ev.fstart = 1'b1;
					end else begin
						n.fst = etl_pkg::F_IDLE;
					end
				end
				if (armed && sedge && !q.cfg.var_len && !vend)
					n.ev.dropped = 1'b1;
			end
			default: n.fst = etl_pkg::F_IDLE;
		endcase
		if (n.ev.valid)
			n.vcnt = q.vcnt + 16'h0001;
		if (n.ev.dropped)
			n.icnt = q.icnt + 16'h0001;

		// ------------------------------------------------------------
		// register access
		// ------------------------------------------------------------
		rv = 32'h0000_0000;
		case (paddr)
			etl_pkg::OFS_CTRL: begin
				rv[etl_pkg::CTRL_ENC] = q.cfg.enc_on;
				rv[etl_pkg::CTRL_EXT] = q.cfg.ext_on;
				rv[etl_pkg::CTRL_FTRIG] = q.cfg.ftrig_on;
				rv[etl_pkg::CTRL_GRAB] = q.cfg.grab;
				rv[etl_pkg::CTRL_AUTO] = q.cfg.auto_dly;
				rv[etl_pkg::CTRL_TF] = q.cfg.tf_en;
				rv[etl_pkg::CTRL_VAR] = q.cfg.var_len;
			end
			etl_pkg::OFS_LINE: begin
				rv[etl_pkg::LINE_SRC +: 3] = q.cfg.src;
				rv[etl_pkg::LINE_ORD +: 2] = q.cfg.order;
				rv[etl_pkg::LINE_DIR +: 2] = q.cfg.dir;
			end
			etl_pkg::OFS_DROP:  rv[15:0] = q.cfg.drop;
			etl_pkg::OFS_MULT:  rv[7:0] = q.cfg.mult;
			etl_pkg::OFS_FRAME: rv[6:0] = q.cfg.det;
			etl_pkg::OFS_LINES: rv[15:0] = q.cfg.lines;
			etl_pkg::OFS_STAT: begin
				rv[15:0] = q.lcnt;
				rv[etl_pkg::STAT_REV +: REV_W] = q.rev;
				rv[etl_pkg::STAT_DUAL] = q.dual_on;
				rv[etl_pkg::STAT_HELD] = q.held;
				rv[etl_pkg::STAT_BUSY] = q.busy;
				rv[etl_pkg::STAT_RUN] = (q.fst == etl_pkg::F_RUN);
			end
			etl_pkg::OFS_CNT: rv = {q.icnt, q.vcnt};
			default: rv = 32'h0000_0000;
		endcase
		if (psel && !penable && !pwrite)
			n.rdata = rv;

		if (psel && penable && pwrite) begin
			case (paddr)
				etl_pkg::OFS_CTRL: begin
					n.cfg.enc_on = pwdata[etl_pkg::CTRL_ENC];
					n.cfg.ext_on = pwdata[etl_pkg::CTRL_EXT];
					n.cfg.ftrig_on = pwdata[etl_pkg::CTRL_FTRIG];
					n.cfg.grab = pwdata[etl_pkg::CTRL_GRAB];
					n.cfg.auto_dly = pwdata[etl_pkg::CTRL_AUTO];
					n.cfg.tf_en = pwdata[etl_pkg::CTRL_TF];
					n.cfg.var_len = pwdata[etl_pkg::CTRL_VAR];
				end
				etl_pkg::OFS_LINE: begin
					n.cfg.src = pwdata[etl_pkg::LINE_SRC +: 3];
					n.cfg.order = pwdata[etl_pkg::LINE_ORD +: 2];
					n.cfg.dir = pwdata[etl_pkg::LINE_DIR +: 2];
				end
				etl_pkg::OFS_DROP:  n.cfg.drop = pwdata[15:0];
				etl_pkg::OFS_MULT:  n.cfg.mult = pwdata[7:0];
				etl_pkg::OFS_FRAME: n.cfg.det = pwdata[6:0];
				etl_pkg::OFS_LINES: n.cfg.lines = pwdata[15:0];
				// any write clears both counters; a same-cycle event is lost
				etl_pkg::OFS_CNT: begin
					n.vcnt = 16'h0000;
					n.icnt = 16'h0000;
				end
				default: n.cfg = q.cfg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.cfg.src <= etl_pkg::SRC_RST;
			q.cfg.mult <= etl_pkg::MULT_RST;
			q.cfg.lines <= etl_pkg::LINES_RST;
			q.cfg.det <= etl_pkg::DET_RST;
			q.fst <= etl_pkg::F_IDLE;
		end else begin
			q <= n;
		end
	end

	assign prdata       = q.rdata;
	assign line_trigger = q.ltrig;
	assign line_capture = q.lcap;
	assign frame_active = (q.fst == etl_pkg::F_RUN);
	assign events       = q.ev;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_no_ev_idle;
		!armed |=> !events.valid && !events.dropped;
	endproperty
	a_no_ev_idle: assert property (p_no_ev_idle) else $error("event while not armed");

	property p_var_no_drop;
		q.cfg.var_len |=> !events.dropped;
	endproperty
	a_var_no_drop: assert property (p_var_no_drop) else $error("dropped in variable");

	property p_edge_no_roll;
		edg && q.cfg.ftrig_on && q.cfg.grab && done_len |=> q.fst == etl_pkg::F_IDLE;
	endproperty
	a_edge_no_roll: assert property (p_edge_no_roll) else $error("edge mode rolled");

	property p_payback;
		fwd_p && q.rev != '0 |-> !qual ##1 q.rev == $past(q.rev) - 1'b1;
	endproperty
	a_payback: assert property (p_payback) else $error("reverse payback wrong");

	property p_rev_ovf;
		rev_p && (&q.rev) |=> events.rev_ovf && (&q.rev);
	endproperty
	a_rev_ovf: assert property (p_rev_ovf) else $error("overflow not flagged");

	property p_drop;
		ds[16] |-> q.dcnt == 16'h0000 ##1 q.dcnt == $past(q.cfg.drop);
	endproperty
	a_drop: assert property (p_drop) else $error("drop count wrong");

	property p_auto_hold;
		q.cfg.auto_dly && q.busy && !line_done |=> !line_trigger && q.busy;
	endproperty
	a_auto_hold: assert property (p_auto_hold) else $error("trigger not held");

	property p_tf_once;
		events.too_fast |-> q.tf_seen ##1 !events.too_fast;
	endproperty
	a_tf_once: assert property (p_tf_once) else $error("too fast repeated");

	property p_fixed_len;
		q.fst == etl_pkg::F_RUN |-> q.lcnt < lim;
	endproperty
	a_fixed_len: assert property (p_fixed_len) else $error("frame exceeded lines");

	property p_line_free;
		p && !q.cfg.auto_dly |=> line_trigger;
	endproperty
	a_line_free: assert property (p_line_free) else $error("line trigger lost");

endmodule : etl_trigger

// *** etl_far.sv ***
`timescale 1ns/100ps
module etl_far (
	// clock
	input  wire logic          pclk,
	// camera side
	input  wire logic          line_trigger,
	output logic               line_done,
	// encoder, sync and trigger pins
	output etl_pkg::etl_pins_t pins
);
	int lat = 3;
	int cnt = 0;
	int pos = 0;
	bit use2 = 1'b0;

	initial begin
		pins = '0;
		line_done = 1'b0;
	end

	// camera finishes a line lat cycles after its trigger
	always @(posedge pclk) begin
		if (line_trigger === 1'b1) begin
			cnt <= lat;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		line_done <= (cnt == 1);
	end

	// quadrature: forward means phase a leads phase b
	task automatic step(input bit fwd, input int n);
		repeat (n) begin
			repeat (12) @(posedge pclk);
			pos = fwd ? (pos + 1) % 4 : (pos + 3) % 4;
			pins.enc_a <= (pos == 1 || pos == 2);
			pins.enc_b <= (pos >= 2);
		end
		repeat (12) @(posedge pclk);
	endtask : step

	task automatic pulse(input int n);
		repeat (n) begin
			repeat (6) @(posedge pclk);
			pins.sync1 <= !use2;
			pins.sync2 <= use2;
			repeat (6) @(posedge pclk);
			pins.sync1 <= 1'b0;
			pins.sync2 <= 1'b0;
		end
		repeat (12) @(posedge pclk);
	endtask : pulse

	task automatic trig(input logic [1:0] t);
		@(posedge pclk);
		pins.trig1 <= t[1];
		pins.trig2 <= t[0];
		repeat (10) @(posedge pclk);
	endtask : trig
endmodule : etl_far

// *** testbench.sv ***
`timescale 1ns/100ps
`define check_eq(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
	$display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module testbench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0000_0000;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	etl_pkg::etl_pins_t pins;
	logic               line_done;
	logic               line_trigger;
	logic               line_capture;
	logic               frame_active;
	etl_pkg::etl_ev_t   events;
	logic [7:0]         ev_v;
	logic [31:0]        q;
	logic               e;
	int                 err_total = 0;
	int                 n_checks = 0;
	int                 cnt [8];
	// ctrl, src, drop, mult, order, edges, expected triggers
	int tb [11][7] = '{'{1,1,0,1,0,4,2}, '{1,2,0,1,0,4,2}, '{1,3,0,1,0,4,4},
		'{2,4,0,1,0,3,3}, '{2,5,0,1,0,3,3}, '{0,3,0,1,0,4,0}, '{1,3,2,1,0,9,3},
		'{1,3,0,3,0,4,12}, '{1,3,1,2,1,3,4}, '{1,3,1,2,0,3,3}, '{1,3,1,2,2,3,3}};
	logic [6:0] dets [6] = '{etl_pkg::DET_LOW, etl_pkg::DET_HIGH, etl_pkg::DET_RISE,
		etl_pkg::DET_FALL, etl_pkg::DET_DRISE, etl_pkg::DET_DFALL};

	always #5 pclk = ~pclk;

	etl_trigger #(.REV_W(2)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .line_done(line_done),
		.line_trigger(line_trigger), .line_capture(line_capture),
		.frame_active(frame_active), .events(events)
	);

	etl_far far_u (.pclk(pclk), .line_trigger(line_trigger), .line_done(line_done), .pins(pins));

	// ------------------------------------------------------------
	// tallies, taken on the falling edge away from the launch race
	// ------------------------------------------------------------
	assign ev_v = {line_trigger, line_capture, events.fstart, events.fend, events.valid,
		events.dropped, events.too_fast, events.rev_ovf};
	always @(negedge pclk) begin
		for (int i = 0; i < 8; i++) begin
			cnt[i] += (ev_v[7 - i] === 1'b1);
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic clr();
		foreach (cnt[i]) cnt[i] = 0;
	endtask : clr

	task automatic rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst

	task automatic cfg(input logic [6:0] d, input logic [15:0] n, input logic [31:0] c);
		rst();
		wr(etl_pkg::OFS_LINE, {29'h0000_0000, etl_pkg::SRC_SYNC1});
		wr(etl_pkg::OFS_LINES, {16'h0000, n});
		wr(etl_pkg::OFS_FRAME, {25'h000_0000, d});
		wr(etl_pkg::OFS_CTRL, c);
		clr();
	endtask : cfg

	function automatic logic [1:0] pp(input logic [6:0] d, input int ph);
		logic inv;
		logic dual;
		inv = d inside {etl_pkg::DET_LOW, etl_pkg::DET_FALL, etl_pkg::DET_DFALL};
		dual = d inside {etl_pkg::DET_DRISE, etl_pkg::DET_DFALL};
		return {inv ^ (ph == 1 || (dual && ph == 2)), dual & (inv ^ (ph == 2))};
	endfunction : pp

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rst();
		apb(1'b0, etl_pkg::OFS_LINE, 32'h0000_0000);
		`check_eq("line reset", 32'h0000_0001, q)
		apb(1'b0, etl_pkg::OFS_LINES, 32'h0000_0000);
		`check_eq("lines reset", 32'h0000_0400, q)
		apb(1'b0, etl_pkg::OFS_FRAME, 32'h0000_0000);
		`check_eq("frame reset", 32'h0000_0004, q)
		apb(1'b0, 8'he0, 32'h0000_0000);
		`check_eq("unmapped error", 1'b1, e)
		wr(etl_pkg::OFS_DROP, 32'hffff_ffff);
		apb(1'b0, etl_pkg::OFS_DROP, 32'h0000_0000);
		`check_eq("drop width", 32'h0000_ffff, q)
		$display("registers done");
		foreach (tb[i]) begin
			rst();
			wr(etl_pkg::OFS_LINE, 32'(tb[i][1] | (tb[i][4] << 4)));
			wr(etl_pkg::OFS_DROP, 32'(tb[i][2]));
			wr(etl_pkg::OFS_MULT, 32'(tb[i][3]));
			wr(etl_pkg::OFS_CTRL, 32'(tb[i][0]));
			clr();
			far_u.use2 = (tb[i][1] == 5);
			if (tb[i][1] < 4) far_u.step(1'b1, tb[i][5]);
			else far_u.pulse(tb[i][5]);
			repeat (20) @(posedge pclk);
			`check_eq("line triggers", tb[i][6], cnt[0])
		end
		$display("sources done");
		rst();
		wr(etl_pkg::OFS_LINE, 32'h0000_0203);
		wr(etl_pkg::OFS_CTRL, 32'h0000_0001);
		clr();
		far_u.step(1'b1, 4);
		`check_eq("b leads only", 0, cnt[0])
		rst();
		wr(etl_pkg::OFS_LINE, 32'h0000_0103);
		wr(etl_pkg::OFS_CTRL, 32'h0000_0001);
		clr();
		far_u.step(1'b1, 4);
		far_u.step(1'b0, 2);
		far_u.step(1'b1, 2);
		`check_eq("after payback", 4, cnt[0])
		far_u.step(1'b1, 3);
		`check_eq("forward again", 7, cnt[0])
		far_u.step(1'b0, 3);
		`check_eq("no overflow yet", 0, cnt[7])
		far_u.step(1'b0, 2);
		`check_eq("overflow", 1'b1, cnt[7] > 0)
		$display("direction done");
		rst();
		far_u.lat = 30;
		wr(etl_pkg::OFS_LINE, 32'h0000_0003);
		wr(etl_pkg::OFS_CTRL, 32'h0000_0031);
		clr();
		far_u.step(1'b1, 3);
		repeat (60) @(posedge pclk);
		`check_eq("held triggers", 2, cnt[0])
		`check_eq("too fast", 1'b1, cnt[6] > 0)
		far_u.lat = 3;
		$display("auto delay done");
		far_u.trig(2'b00);
		cfg(etl_pkg::DET_RISE, 16'h0004, 32'h0000_0006);
		far_u.trig(2'b10);
		far_u.pulse(3);
		far_u.trig(2'b00);
		`check_eq("no grab start", 0, cnt[2])
		`check_eq("no grab valid", 0, cnt[4])
		wr(etl_pkg::OFS_CTRL, 32'h0000_000e);
		clr();
		far_u.trig(2'b10);
		far_u.pulse(2);
		far_u.trig(2'b00);
		far_u.trig(2'b10);
		far_u.pulse(6);
		`check_eq("captured", 4, cnt[1])
		`check_eq("frame starts", 1, cnt[2])
		`check_eq("frame ends", 1, cnt[3])
		`check_eq("valid", 1, cnt[4])
		`check_eq("ignored", 1, cnt[5])
		`check_eq("all lines", 8, cnt[0])
		`check_eq("frame idle", 1'b0, frame_active)
		apb(1'b0, etl_pkg::OFS_CNT, 32'h0000_0000);
		`check_eq("trigger counts", 32'h0001_0001, q)
		far_u.trig(2'b00);
		cfg(etl_pkg::DET_HIGH, 16'h0003, 32'h0000_000e);
		far_u.trig(2'b10);
		far_u.pulse(7);
		far_u.trig(2'b00);
		far_u.pulse(5);
		`check_eq("rolled lines", 9, cnt[1])
		`check_eq("rolled starts", 3, cnt[2])
		`check_eq("rolled ends", 3, cnt[3])
		$display("fixed frames done");
		foreach (dets[i]) begin
			far_u.trig(pp(dets[i], 0));
			cfg(dets[i], 16'h0004, 32'h0000_004e);
			far_u.trig(pp(dets[i], 1));
			far_u.pulse(3);
			far_u.trig(pp(dets[i], 2));
			far_u.pulse(3);
			`check_eq("var lines", (i == 2 || i == 3) ? 4 : 3, cnt[1])
			`check_eq("var starts", 1, cnt[2])
			`check_eq("var ends", 1, cnt[3])
			`check_eq("var ignored", 0, cnt[5])
		end
		$display("variable frames done");
		report_and_stop();
	end
endmodule : testbench
